// *** verilog/cfoa_core.sv ***
// Purpose: Condition flag update and effective address forming of an 8-bit core.
// Assumes: Requests come from logic on clk_i; AXI4-Lite master follows the protocol.
// Notes:   Answer appears one cycle after the request, with no added cycles.
//
// Operation
// RULE1: Negative flag bit 2 follows top bit of result or moved value.
// RULE2: Zero flag bit 1 set exactly when result or moved value is zero.
// RULE3: Carry flag bit 0 is carry out of bit 7 or borrow.
// RULE4: Bit-test branch, shift and rotate write carry from their own definition.
// RULE5: Memory, registers and ports share one 64 KB address space.
// RULE6: Every mode except no-operand yields a 16-bit effective address; here only page-zero and full-address modes set has_ea.
// RULE7: Address forming adds no cycles beyond normal bus accesses.
// RULE8: Sixteen modes exist; five are formed here.
// RULE9: No-operand mode needs no memory access beyond the opcode fetch.
// RULE10: Branch offset is a signed byte after the opcode, -128 to +127.
// RULE11: Taken branch adds sign-extended offset to PC; else next instruction.
// RULE12: Literal mode bytes are the operand value, width fixed by instruction.
// RULE13: Page-zero mode forces high address byte to zero, $0000 to $00FF.
// RULE14: Index-pair page-zero access uses addressed byte then next byte.
// RULE15: Test branches reach operand by listed mode, target by branch offset.
// RULE16: Full-address mode takes whole 16-bit address from instruction bytes.
// RULE17: Moves locate source and destination by independent modes.
// RULE18: Interrupt mask bit 3 blocks maskable interrupts while set.
// RULE19: Flag register bits 6 and 5 always read as one.
// RULE20: Address sums wrap modulo 64 KB.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cfoa_defs.svh"

module cfoa_core #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              req_valid_i,
    input  wire cfoa_pkg::cfoa_req_t req_i,
    input  wire logic              irq_req_i,
    output logic                   ans_valid_o,
    output cfoa_pkg::cfoa_ans_t    ans_o,
    output logic [7:0]             flags_o,
    output logic                   irq_take_o,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ======================================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // Two flops release the asynchronous reset in step with the clock.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ======================================================================
    // Address forming
    logic [7:0]          ib [0:3];
    logic [1:0]          src_len;
    logic [2:0]          dst_idx;
    logic [7:0]          br_off;
    logic [15:0]         br_sum;
    cfoa_pkg::cfoa_ans_t ans_d;
    logic [7:0]          flags_q;
    logic [7:0]          flags_d;

    assign ib[0] = req_i.byte1;
    assign ib[1] = req_i.byte2;
    assign ib[2] = req_i.byte3;
    assign ib[3] = 8'h00;

    // Number of instruction bytes that a mode takes after the opcode.
    function automatic logic [1:0] len_of(input cfoa_pkg::cfoa_mode_t m, input logic w);
        case (m)
            cfoa_pkg::CFOA_MODE_REL: len_of = 2'h1;
            cfoa_pkg::CFOA_MODE_IMM: len_of = w ? 2'h2 : 2'h1;
            cfoa_pkg::CFOA_MODE_DIR: len_of = 2'h1;
            cfoa_pkg::CFOA_MODE_EXT: len_of = 2'h2;
            default:                 len_of = 2'h0;
        endcase
    endfunction : len_of

    // Effective address from the mode and its instruction bytes.
    function automatic logic [15:0] ea_of(input cfoa_pkg::cfoa_mode_t m,
                                          input logic [7:0] b0, input logic [7:0] b1);
        case (m)
            // RULE13 page-zero high byte
            cfoa_pkg::CFOA_MODE_DIR: ea_of = {`CFOA_PAGE0_HI, b0};
            // RULE16 full address
            cfoa_pkg::CFOA_MODE_EXT: ea_of = {b0, b1};
            default:                 ea_of = 16'h0000;
        endcase
    endfunction : ea_of

    // The whole answer is combinational from the request, so it costs no cycle.
    always_comb begin
        src_len = len_of(req_i.mode, req_i.wide);
        dst_idx = {1'b0, src_len};
        // RULE10 offset byte location
        br_off  = (req_i.mode == cfoa_pkg::CFOA_MODE_REL) ? ib[0] : ib[dst_idx[1:0]];
        // RULE20 sum wraps in 16 bits
        br_sum  = req_i.pc + {{8{br_off[7]}}, br_off};
        ans_d   = '0;
        // RULE6 address only for page-zero and full-address modes
        // RULE9 no-operand leaves no address
        ans_d.has_ea  = (req_i.mode == cfoa_pkg::CFOA_MODE_DIR)
                     || (req_i.mode == cfoa_pkg::CFOA_MODE_EXT);
        ans_d.ea      = ea_of(req_i.mode, ib[0], ib[1]);
        // RULE14 index pair second byte
        ans_d.ea_next = ans_d.ea + 16'h0001;
        // RULE17 independent destination mode
        ans_d.dst_ea  = ea_of(req_i.dst_mode, ib[dst_idx[1:0]], ib[dst_idx[1:0] + 2'h1]);
        // RULE12 literal bytes are the value
        ans_d.literal = (req_i.mode == cfoa_pkg::CFOA_MODE_IMM);
        ans_d.operand = req_i.wide ? {ib[0], ib[1]} : {8'h00, ib[0]};
        // RULE11 branch target or fall through
        // RULE15 implied branch offset after test operand
        ans_d.taken   = req_i.branch && req_i.cond;
        ans_d.next_pc = ans_d.taken ? br_sum : req_i.pc;
    end

    // RULE7 answer one cycle after request
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ans_valid_o <= 1'b0;
            ans_o       <= '0;
        end else begin
            ans_valid_o <= req_valid_i;
            if (req_valid_i) begin
                ans_o <= ans_d;
            end
        end
    end

    // ======================================================================
    // Condition flags
    logic [8:0]  sum9;
    logic        cin;
    logic [15:0] res;
    logic        res_wide;
    logic        hw_upd;
    logic        flags_wr;

    // Arithmetic result with carry out of bit 7 or borrow.
    always_comb begin
        cin  = req_i.use_cin && flags_q[`CFOA_BIT_C];
        sum9 = req_i.sub ? ({1'b0, req_i.acc} - {1'b0, req_i.opnd} - {8'h00, cin})
                         : ({1'b0, req_i.acc} + {1'b0, req_i.opnd} + {8'h00, cin});
        res      = (req_i.op == cfoa_pkg::CFOA_OP_ARITH) ? {8'h00, sum9[7:0]} : req_i.value;
        res_wide = req_i.wide && (req_i.op == cfoa_pkg::CFOA_OP_MOVE);
        hw_upd   = req_valid_i && (req_i.op != cfoa_pkg::CFOA_OP_NONE);
    end

    // Software write first, then the instruction result wins on N and Z, and on C for arithmetic and carry updates.
    always_comb begin
        flags_d = flags_q;
        if (flags_wr) begin
            flags_d = w_data_q[7:0];
        end
        if (hw_upd) begin
            // RULE1 negative from top bit
            flags_d[`CFOA_BIT_N] = res_wide ? res[15] : res[7];
            // RULE2 zero on all zeros
            flags_d[`CFOA_BIT_Z] = res_wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
            // RULE3 carry or borrow
            if (req_i.op == cfoa_pkg::CFOA_OP_ARITH) begin
                flags_d[`CFOA_BIT_C] = sum9[8];
            end
            // RULE4 instruction-defined carry
            if (req_i.op == cfoa_pkg::CFOA_OP_CARRY) begin
                flags_d[`CFOA_BIT_C] = req_i.carry_val;
            end
        end
        // RULE19 fixed ones
        flags_d = flags_d | `CFOA_FLAGS_ONES;
    end

    // Flag register.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `CFOA_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign flags_o = flags_q;

    // RULE18 mask gates interrupts
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_take_o <= 1'b0;
        end else begin
            irq_take_o <= irq_req_i && !flags_q[`CFOA_BIT_I];
        end
    end

    // ======================================================================
    // AXI4-Lite slave
    logic [ADDR_W-1:0] aw_addr_q;
    logic [3:0]        w_strb_q;
    logic [31:0]       w_data_q;
    logic              wr_go;

    // Address and data are latched in either order; the write fires once both are held.
    assign wr_go    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign flags_wr = wr_go && (aw_addr_q == `CFOA_OFF_FLAGS) && w_strb_q[0];

    // Write channels.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CFOA_RESP_OKAY;
            aw_addr_q     <= '0;
            w_strb_q      <= 4'h0;
            w_data_q      <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q == `CFOA_OFF_FLAGS) ? `CFOA_RESP_OKAY
                                                               : `CFOA_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channels; the address map shows flags, last address and last target.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CFOA_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `CFOA_RESP_OKAY;
                case (s_axi_araddr)
                    `CFOA_OFF_FLAGS:  s_axi_rdata <= {24'h00_0000, flags_q};
                    // RULE5 one 64 KB address space
                    `CFOA_OFF_EA:     s_axi_rdata <= {16'h0000, ans_o.ea};
                    `CFOA_OFF_TARGET: s_axi_rdata <= {16'h0000, ans_o.next_pc};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `CFOA_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // RULE8 five of sixteen modes
    // The unformed mode codes give no address; other units of the core serve them.

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_req(cfoa_pkg::cfoa_mode_t m);
        req_valid_i && req_i.mode == m;
    endsequence
    sequence s_ans;
        ##1 ans_valid_o;
    endsequence

    property p_neg_move;
        req_valid_i && req_i.op == cfoa_pkg::CFOA_OP_MOVE
            |=> flags_q[`CFOA_BIT_N] == ($past(req_i.wide) ? $past(req_i.value[15])
                                                          : $past(req_i.value[7]));
    endproperty
    a_neg_move: assert property (p_neg_move) else $error("negative flag wrong"); // RULE1

    property p_zero;
        req_valid_i && req_i.op == cfoa_pkg::CFOA_OP_LOGIC
            |=> flags_q[`CFOA_BIT_Z] == ($past(req_i.value[7:0]) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE2

    property p_carry_add;
        req_valid_i && req_i.op == cfoa_pkg::CFOA_OP_ARITH && !req_i.sub && !req_i.use_cin
            |=> flags_q[`CFOA_BIT_C] == ((9'($past(req_i.acc)) + 9'($past(req_i.opnd))) > 9'h0FF);
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("carry flag wrong"); // RULE3

    property p_carry_own;
        req_valid_i && req_i.op == cfoa_pkg::CFOA_OP_CARRY
            |=> flags_q[`CFOA_BIT_C] == $past(req_i.carry_val);
    endproperty
    a_carry_own: assert property (p_carry_own) else $error("shift carry wrong"); // RULE4

    property p_latency;
        req_valid_i |-> s_ans;
    endproperty
    a_latency: assert property (p_latency) else $error("answer late"); // RULE7

    property p_page0;
        s_req(cfoa_pkg::CFOA_MODE_DIR) |-> s_ans ##0 (ans_o.ea[15:8] == 8'h00 && ans_o.has_ea);
    endproperty
    a_page0: assert property (p_page0) else $error("page-zero address high"); // RULE13

    property p_ext;
        s_req(cfoa_pkg::CFOA_MODE_EXT) |=> ans_o.ea == {$past(req_i.byte1), $past(req_i.byte2)};
    endproperty
    a_ext: assert property (p_ext) else $error("full address wrong"); // RULE16

    property p_inh;
        s_req(cfoa_pkg::CFOA_MODE_NONE) |=> !ans_o.has_ea;
    endproperty
    a_inh: assert property (p_inh) else $error("no-operand gave address"); // RULE9

    property p_branch;
        s_req(cfoa_pkg::CFOA_MODE_REL) ##0 req_i.branch
            |=> ans_o.next_pc == ($past(req_i.cond)
                ? 16'($past(req_i.pc) + {{8{$past(req_i.byte1[7])}}, $past(req_i.byte1)})
                : $past(req_i.pc));
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong"); // RULE11

    property p_pair;
        ans_valid_o |-> ans_o.ea_next == 16'(ans_o.ea + 16'h0001);
    endproperty
    a_pair: assert property (p_pair) else $error("pair second address wrong"); // RULE14

    property p_ones;
        flags_q[`CFOA_BIT_ONE_HI] && flags_q[`CFOA_BIT_ONE_LO];
    endproperty
    a_ones: assert property (p_ones) else $error("fixed one bits cleared"); // RULE19

    property p_mask;
        irq_req_i && flags_q[`CFOA_BIT_I] |=> !irq_take_o;
    endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt taken"); // RULE18

endmodule : cfoa_core
`default_nettype wire

// *** shared/cfoa_defs.svh ***
// Purpose: Offsets, field positions, reset values and fixed figures of the flags block.
// Assumes: Included by its bare name wherever the constants are needed.
// Notes:   Definitions only.
`ifndef CFOA_DEFS_SVH
`define CFOA_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses on the register bus)
`define CFOA_OFF_FLAGS   8'h00
`define CFOA_OFF_EA      8'h04
`define CFOA_OFF_TARGET  8'h08

// ==========================================================================
// Condition flag bit positions
`define CFOA_BIT_C       0
`define CFOA_BIT_Z       1
`define CFOA_BIT_N       2
`define CFOA_BIT_I       3
`define CFOA_BIT_ONE_LO  5
`define CFOA_BIT_ONE_HI  6

// ==========================================================================
// Reset values and fixed figures
`define CFOA_FLAGS_RST   8'h68
`define CFOA_FLAGS_ONES  8'h60
`define CFOA_PAGE0_HI    8'h00
`define CFOA_RESP_OKAY   2'h0
`define CFOA_RESP_SLVERR 2'h2

`endif

// *** shared/cfoa_pkg.sv ***
// Purpose: Types shared by the flags and addressing block.
// Assumes: Nothing beyond the language.
// Notes:   Mode codes span a 4-bit space of sixteen modes.
package cfoa_pkg;

    // ======================================================================
    // Addressing modes; the unnamed codes belong to other parts of the core.
    typedef enum logic [3:0] {
        CFOA_MODE_NONE = 4'h0,
        CFOA_MODE_REL  = 4'h1,
        CFOA_MODE_DIR  = 4'h2,
        CFOA_MODE_IMM  = 4'h3,
        CFOA_MODE_EXT  = 4'h6
    } cfoa_mode_t;

    // ======================================================================
    // Flag update classes of an instruction.
    typedef enum logic [2:0] {
        CFOA_OP_NONE  = 3'h0,
        CFOA_OP_ARITH = 3'h1,
        CFOA_OP_LOGIC = 3'h3,
        CFOA_OP_MOVE  = 3'h2,
        CFOA_OP_CARRY = 3'h6
    } cfoa_op_t;

    // One decoded instruction offered by the core.
    typedef struct packed {
        cfoa_mode_t  mode;
        cfoa_mode_t  dst_mode;
        cfoa_op_t    op;
        logic        wide;
        logic        sub;
        logic        use_cin;
        logic        branch;
        logic        cond;
        logic [7:0]  byte1;
        logic [7:0]  byte2;
        logic [7:0]  byte3;
        logic [15:0] pc;
        logic [7:0]  acc;
        logic [7:0]  opnd;
        logic [15:0] value;
        logic        carry_val;
    } cfoa_req_t;

    // Addresses and operand formed for that instruction.
    typedef struct packed {
        logic        has_ea;
        logic        literal;
        logic [15:0] ea;
        logic [15:0] ea_next;
        logic [15:0] dst_ea;
        logic [15:0] operand;
        logic        taken;
        logic [15:0] next_pc;
    } cfoa_ans_t;

endpackage : cfoa_pkg

// *** tb/cfoa_mem_model.sv ***
// Purpose: Behavioural model of the unified 64 KB memory and peripheral space.
// Assumes: The bench reads it combinationally when it fetches operand bytes.
// Notes:   Each location holds the low byte of its own address.
`timescale 1ns/1ns
`default_nettype none

module cfoa_mem_model (
    input  wire logic [15:0] addr_i,
    output logic [7:0]       data_o
);
    logic [7:0] mem_q [65536];

    // Fill every location with a pattern that names its address.
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem_q[i] = i[7:0];
        end
    end

    // one shared space
    // Memory, registers and ports all answer from this single array.
    assign data_o = mem_q[addr_i];
endmodule : cfoa_mem_model
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench of the flags and addressing block.
// Assumes: One 100 MHz clock; registers reached as an AXI4-Lite master.
// Notes:   Expected values are worked out from the flag and mode definitions.
`timescale 1ns/1ns
`default_nettype none
`include "cfoa_defs.svh"

module tb;
    logic                clk_i;
    logic                rst_n_i;
    logic                req_valid_i;
    logic                irq_req_i;
    logic                ans_valid_o;
    logic                irq_take_o;
    logic [7:0]          flags_o;
    cfoa_pkg::cfoa_req_t req_i;
    cfoa_pkg::cfoa_req_t r;
    cfoa_pkg::cfoa_ans_t ans_o;
    logic [7:0]          awaddr, araddr;
    logic [31:0]         wdata, rdata, rd;
    logic [3:0]          wstrb;
    logic [1:0]          bresp, rresp, rs;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic [15:0]         mem_addr;
    logic [7:0]          mem_data;
    int                  errors;
    int                  tests_run;

    cfoa_core cfoa_core_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .irq_req_i(irq_req_i), .ans_valid_o(ans_valid_o), .ans_o(ans_o),
        .flags_o(flags_o), .irq_take_o(irq_take_o), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    cfoa_mem_model cfoa_mem_model_inst (.addr_i(mem_addr), .data_o(mem_data));

    // Free-running 100 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ======================================================================
    // Access tasks
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Offers one instruction for a single cycle; the answer must follow one edge later.
    task automatic run_req();
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i       <= r;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk("ans_valid", 16'h0001, {15'h0000, ans_valid_o});
    endtask : run_req

    // Runs a flag update; k packs wide, sub, use_cin and carry_val.
    task automatic fl(input cfoa_pkg::cfoa_op_t o, input logic [7:0] a, input logic [7:0] b,
                      input logic [15:0] v, input logic [3:0] k, input logic [2:0] e);
        r = '0;
        r.op = o;
        r.acc = a;
        r.opnd = b;
        r.value = v;
        {r.wide, r.sub, r.use_cin, r.carry_val} = k;
        run_req();
        chk("flags_nzc", {13'h0000, e}, {13'h0000, flags_o[2:0]});
    endtask : fl

    // Prepares an addressing request with a branch of the given condition.
    task automatic md(input cfoa_pkg::cfoa_mode_t m, input logic [7:0] b1,
                      input logic [7:0] b2, input logic [15:0] pc, input logic c);
        r = '0;
        r.mode = m;
        r.byte1 = b1;
        r.byte2 = b2;
        r.pc = pc;
        r.branch = 1'b1;
        r.cond = c;
    endtask : md

    // Writes one register; address and data are released as each is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge clk_i);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_i);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk_i);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    // Reads one register and keeps its data and response.
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short well beyond the hundred or so cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // ======================================================================
    // Test sequence
    initial begin
        {rst_n_i, req_valid_i, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        irq_req_i = 1'b1;
        req_i = '0;
        mem_addr = 16'h0000;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("flags_rst", {8'h00, `CFOA_FLAGS_RST}, {8'h00, flags_o});
        chk("irq_masked", 16'h0000, {15'h0000, irq_take_o});
        $display("test reset done");
        fl(cfoa_pkg::CFOA_OP_ARITH, 8'hFF, 8'h01, 16'h0000, 4'h0, 3'b011);
        fl(cfoa_pkg::CFOA_OP_ARITH, 8'h00, 8'h01, 16'h0000, 4'h4, 3'b101);
        fl(cfoa_pkg::CFOA_OP_ARITH, 8'h7F, 8'h00, 16'h0000, 4'h2, 3'b100);
        fl(cfoa_pkg::CFOA_OP_ARITH, 8'h05, 8'h03, 16'h0000, 4'h4, 3'b000);
        fl(cfoa_pkg::CFOA_OP_MOVE, 8'h00, 8'h00, 16'h0000, 4'h8, 3'b010);
        fl(cfoa_pkg::CFOA_OP_MOVE, 8'h00, 8'h00, 16'h8000, 4'h8, 3'b100);
        fl(cfoa_pkg::CFOA_OP_MOVE, 8'h00, 8'h00, 16'h0100, 4'h8, 3'b000);
        fl(cfoa_pkg::CFOA_OP_MOVE, 8'h00, 8'h00, 16'h1200, 4'h0, 3'b010);
        fl(cfoa_pkg::CFOA_OP_CARRY, 8'h00, 8'h00, 16'h0001, 4'h1, 3'b001);
        fl(cfoa_pkg::CFOA_OP_LOGIC, 8'h00, 8'h00, 16'h0000, 4'h0, 3'b011);
        fl(cfoa_pkg::CFOA_OP_CARRY, 8'h00, 8'h00, 16'h0080, 4'h0, 3'b100);
        fl(cfoa_pkg::CFOA_OP_NONE, 8'h00, 8'h00, 16'h0000, 4'h0, 3'b100);
        $display("test flags done");
        md(cfoa_pkg::CFOA_MODE_DIR, 8'hFF, 8'h00, 16'h0000, 1'b0);
        run_req();
        chk("dir_ea", 16'h00FF, ans_o.ea);
        chk("dir_next", 16'h0100, ans_o.ea_next);
        md(cfoa_pkg::CFOA_MODE_IMM, 8'h12, 8'h34, 16'h0000, 1'b0);
        r.wide = 1'b1;
        run_req();
        chk("imm_wide", 16'h1234, ans_o.operand);
        chk("imm_lit", 16'h0001, {15'h0000, ans_o.literal});
        mem_addr = 16'h1234;
        #1 md(cfoa_pkg::CFOA_MODE_EXT, mem_data, 8'h00, 16'h0000, 1'b0);
        mem_addr = 16'h1235;
        #1 r.byte2 = mem_data;
        run_req();
        chk("ext_ea", 16'h3435, ans_o.ea);
        md(cfoa_pkg::CFOA_MODE_NONE, 8'h55, 8'h00, 16'h0000, 1'b0);
        run_req();
        chk("none_has_ea", 16'h0000, {15'h0000, ans_o.has_ea});
        md(cfoa_pkg::CFOA_MODE_REL, 8'h80, 8'h00, 16'h0010, 1'b1);
        run_req();
        chk("rel_back", 16'hFF90, ans_o.next_pc);
        md(cfoa_pkg::CFOA_MODE_REL, 8'h7F, 8'h00, 16'hFFF0, 1'b1);
        run_req();
        chk("rel_wrap", 16'h006F, ans_o.next_pc);
        md(cfoa_pkg::CFOA_MODE_REL, 8'h05, 8'h00, 16'h0200, 1'b0);
        run_req();
        chk("rel_untaken", 16'h0200, ans_o.next_pc);
        md(cfoa_pkg::CFOA_MODE_DIR, 8'h40, 8'hFE, 16'h0100, 1'b1);
        run_req();
        chk("test_ea", 16'h0040, ans_o.ea);
        chk("test_target", 16'h00FE, ans_o.next_pc);
        md(cfoa_pkg::CFOA_MODE_DIR, 8'h10, 8'h20, 16'h0300, 1'b0);
        r.dst_mode = cfoa_pkg::CFOA_MODE_DIR;
        run_req();
        chk("move_src", 16'h0010, ans_o.ea);
        chk("move_dst", 16'h0020, ans_o.dst_ea);
        $display("test modes done");
        axi_rd(`CFOA_OFF_EA);
        chk("reg_ea", 16'h0010, rd[15:0]);
        chk("rd_resp", 16'h0000, {14'h0000, rs});
        axi_rd(`CFOA_OFF_TARGET);
        chk("reg_target", 16'h0300, rd[15:0]);
        axi_wr(`CFOA_OFF_EA, 32'h0000_FFFF);
        chk("wr_ro_resp", {14'h0000, `CFOA_RESP_SLVERR}, {14'h0000, rs});
        axi_rd(8'h0C);
        chk("rd_unmapped", {14'h0000, `CFOA_RESP_SLVERR}, {14'h0000, rs});
        axi_wr(`CFOA_OFF_FLAGS, 32'h0000_0000);
        chk("wr_resp", 16'h0000, {14'h0000, rs});
        axi_rd(`CFOA_OFF_FLAGS);
        chk("flags_ones", 16'h0060, rd[15:0]);
        repeat (2) @(posedge clk_i);
        chk("irq_open", 16'h0001, {15'h0000, irq_take_o});
        axi_wr(`CFOA_OFF_FLAGS, 32'h0000_0008);
        repeat (2) @(posedge clk_i);
        chk("irq_shut", 16'h0000, {15'h0000, irq_take_o});
        chk("flags_back", 16'h0068, {8'h00, flags_o});
        $display("test register bus done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
